//--- rtl/lpw_ctrl.sv
// Operation
// - stop without osc option kills clock outputs
// - stop on vco clock clears base select
// - stop with osc option keeps oscillator, clock outputs and bus clock, pll off
// - clock generator stays active in wait
// - watchdog counts in wait, stopped/cleared in stop
// - stop enable bit gates stop instruction
// - external and keypad wake when unmasked
// - supply monitor reset exits wait or stop
// - serial runs in wait, halts in stop
// - spi halts in stop, reset exit resets it
// - timers run in wait, freeze in stop
// - timebase count unreadable in wait/stop
// - timebase runs in stop only with osc
// - reset class exits use reset vector
// - external falling edge uses own vector
// - break uses break vector pair
// - pll and keypad use separate vectors
// - first timer three ascending vector pairs
// - second timer overflow and channel vectors
// - spi transmitter and receiver vectors
// - serial transmit, receive, error vectors
// - converter shares keypad, timebase own vector
// - stop disables cpu and maybe bus clock
module lpw_ctrl (
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_srst,
  // cpu instruction strobes
  input  wire logic                    i_wait_exec,
  input  wire logic                    i_stop_exec,
  // configuration bits
  input  wire logic                    i_osc_run_in_stop,
  input  wire logic                    i_stop_enable,
  input  wire logic                    i_base_clock_select,
  input  wire logic                    i_pll_power_on,
  input  wire logic                    i_vco_drives_bus,
  // external pins (asynchronous)
  input  wire logic                    i_ext_reset_n,
  input  wire logic                    i_ext_int_pin_n,
  input  wire logic                    i_supply_low,
  // interrupt masks and supply monitor options
  input  wire logic                    i_ext_int_mask,
  input  wire logic                    i_keypad_int_mask,
  input  wire logic                    i_supply_mon_enable,
  input  wire logic                    i_supply_mon_reset_enable,
  // wake requests from on-chip units
  input  wire logic                    i_keypad_req,
  input  wire logic                    i_wdog_timeout,
  input  wire logic                    i_break_req,
  input  wire logic                    i_pll_req,
  input  wire lpw_pkg::lpw_periph_req_t i_periph_req,
  // cpu side
  output logic                         o_cpu_clk_en,
  output logic                         o_bus_clk_en,
  output logic                         o_wake,
  output logic                         o_reset_exit,
  output logic                         o_stop_refused,
  output logic [15:0]                  o_vec_hi_addr,
  output logic [15:0]                  o_vec_lo_addr,
  output lpw_pkg::lpw_mode_t           o_mode,
  // clock generator side
  output lpw_pkg::lpw_clk_gate_t       o_clk_gate,
  output logic                         o_bcs_clear,
  // peripheral side
  output lpw_pkg::lpw_unit_ctl_t       o_unit_ctl,
  output logic                         o_spi_reset
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [2:0] pin_sync;         // {reset_n, ext_int_n, supply_low}
  logic       rst_pin_n_s;      // synced reset pin
  logic       ext_int_n_s;      // synced external interrupt pin
  logic       supply_low_s;     // synced supply-low flag

  lpw_sync #(
    .W (3)
  ) u_pin_sync (
    .i_core_clk  (i_core_clk),
    .i_srst      (i_srst),
    .i_async     ({i_ext_reset_n, i_ext_int_pin_n, i_supply_low}),
    .i_reset_val (3'b110),
    .o_sync      (pin_sync)
  );

  assign rst_pin_n_s  = pin_sync[2];
  assign ext_int_n_s  = pin_sync[1];
  assign supply_low_s = pin_sync[0];

  // ==========================================================================
  // external interrupt edge detect
  // ==========================================================================
  logic ext_int_prev_q;         // last synced pin level
  logic ext_int_prev_d;
  logic ext_fall;               // high-to-low seen this cycle

  // edge reads only the second stage, never the first
  always_comb begin
    ext_int_prev_d = ext_int_n_s;
    ext_fall       = ext_int_prev_q & ~ext_int_n_s;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ext_int_prev_q <= 1'b1;
    end else begin
      ext_int_prev_q <= ext_int_prev_d;
    end
  end

  // ==========================================================================
  // wake source collection
  // ==========================================================================
  logic                        reset_src;    // any reset-class source
  logic                        supply_rst;   // supply monitor reset request
  logic [lpw_pkg::LPW_NSRC-1:0] wait_pend;   // sources that end wait
  logic [lpw_pkg::LPW_NSRC-1:0] stop_pend;   // sources that end stop
  logic [lpw_pkg::LPW_NSRC-1:0] pend;        // chosen by current mode
  logic                        pick_valid;
  logic [3:0]                  pick_idx;
  lpw_pkg::lpw_mode_t          mode_q;     // current low-power mode

  // wait accepts every source; stop accepts only the ones with no clock need
  always_comb begin
    supply_rst = i_supply_mon_enable & i_supply_mon_reset_enable
                 & supply_low_s;
    reset_src  = ~rst_pin_n_s | i_wdog_timeout | supply_rst;
    wait_pend  = '0;
    wait_pend[lpw_pkg::LPW_SRC_RESET]   = reset_src;
    wait_pend[lpw_pkg::LPW_SRC_BREAK]   = i_break_req;
    wait_pend[lpw_pkg::LPW_SRC_EXTINT]  = ext_fall & ~i_ext_int_mask;
    wait_pend[lpw_pkg::LPW_SRC_PLL]     = i_pll_req;
    wait_pend[lpw_pkg::LPW_SRC_T1_CH0]  = i_periph_req.t1_ch0;
    wait_pend[lpw_pkg::LPW_SRC_T1_CH1]  = i_periph_req.t1_ch1;
    wait_pend[lpw_pkg::LPW_SRC_T1_OVF]  = i_periph_req.t1_ovf;
    wait_pend[lpw_pkg::LPW_SRC_T2_CH0]  = i_periph_req.t2_ch0;
    wait_pend[lpw_pkg::LPW_SRC_T2_OVF]  = i_periph_req.t2_ovf;
    wait_pend[lpw_pkg::LPW_SRC_SPI_RX]  = i_periph_req.spi_rx;
    wait_pend[lpw_pkg::LPW_SRC_SPI_TX]  = i_periph_req.spi_tx;
    wait_pend[lpw_pkg::LPW_SRC_SCI_ERR] = i_periph_req.sci_err;
    wait_pend[lpw_pkg::LPW_SRC_SCI_RX]  = i_periph_req.sci_rx;
    wait_pend[lpw_pkg::LPW_SRC_SCI_TX]  = i_periph_req.sci_tx;
    wait_pend[lpw_pkg::LPW_SRC_KEYPAD]  = (i_keypad_req & ~i_keypad_int_mask)
                                          | i_periph_req.adc_done;
    wait_pend[lpw_pkg::LPW_SRC_TBM]     = i_periph_req.periodic_timebase;
    // watchdog has no clock in stop, so only pin and supply resets count
    stop_pend  = '0;
    stop_pend[lpw_pkg::LPW_SRC_RESET]   = ~rst_pin_n_s | supply_rst;
    stop_pend[lpw_pkg::LPW_SRC_BREAK]   = i_break_req;
    stop_pend[lpw_pkg::LPW_SRC_EXTINT]  = ext_fall & ~i_ext_int_mask;
    stop_pend[lpw_pkg::LPW_SRC_KEYPAD]  = i_keypad_req & ~i_keypad_int_mask;
    stop_pend[lpw_pkg::LPW_SRC_TBM]     = i_periph_req.periodic_timebase
                                          & i_osc_run_in_stop;
    unique case (mode_q)
      lpw_pkg::LPW_WAIT: pend = wait_pend;
      lpw_pkg::LPW_STOP: pend = stop_pend;
      default:           pend = '0;
    endcase
  end

  lpw_vec_pick #(
    .N  (lpw_pkg::LPW_NSRC),
    .IW (4)
  ) u_pick (
    .i_pending (pend),
    .o_valid   (pick_valid),
    .o_index   (pick_idx)
  );

  // ==========================================================================
  // mode state machine
  // ==========================================================================
  lpw_pkg::lpw_mode_t mode_d;
  logic               wake_d;
  logic               reset_exit_d;
  logic               refused_d;
  logic               bcs_clear_d;
  logic               spi_reset_d;
  logic [15:0]        vec_hi_d;
  logic [15:0]        vec_lo_d;

  // entry on instruction strobe, exit on highest pending source
  always_comb begin
    mode_d       = mode_q;
    wake_d       = 1'b0;
    reset_exit_d = 1'b0;
    refused_d    = 1'b0;
    bcs_clear_d  = 1'b0;
    spi_reset_d  = 1'b0;
    vec_hi_d     = o_vec_hi_addr;
    vec_lo_d     = o_vec_lo_addr;
    unique case (mode_q)
      lpw_pkg::LPW_RUN: begin
        if (i_stop_exec) begin
          if (i_stop_enable) begin
            mode_d      = lpw_pkg::LPW_STOP;
            // vco clock on the bus source: fall back to crystal for recovery
            bcs_clear_d = i_vco_drives_bus & i_base_clock_select;
          end else begin
            refused_d   = 1'b1;
          end
        end else if (i_wait_exec) begin
          mode_d = lpw_pkg::LPW_WAIT;
        end
      end
      lpw_pkg::LPW_WAIT,
      lpw_pkg::LPW_STOP: begin
        if (pick_valid) begin
          mode_d       = lpw_pkg::LPW_RUN;
          wake_d       = 1'b1;
          reset_exit_d = (pick_idx == 4'(lpw_pkg::LPW_SRC_RESET));
          // a reset out of stop aborts any spi transfer
          spi_reset_d  = reset_exit_d
                         & (mode_q == lpw_pkg::LPW_STOP);
          vec_hi_d     = lpw_pkg::LPW_VEC_ADDR[pick_idx];
          vec_lo_d     = lpw_pkg::LPW_VEC_ADDR[pick_idx]
                         + lpw_pkg::LPW_VEC_PAIR_STEP;
        end
      end
      default: begin
        mode_d = lpw_pkg::LPW_RUN;   // illegal code recovers to run
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      mode_q         <= lpw_pkg::LPW_RUN;
      o_wake         <= 1'b0;
      o_reset_exit   <= 1'b0;
      o_stop_refused <= 1'b0;
      o_bcs_clear    <= 1'b0;
      o_spi_reset    <= 1'b0;
      o_vec_hi_addr  <= lpw_pkg::LPW_VEC_IDLE;
      o_vec_lo_addr  <= lpw_pkg::LPW_VEC_IDLE;
    end else begin
      mode_q         <= mode_d;
      o_wake         <= wake_d;
      o_reset_exit   <= reset_exit_d;
      o_stop_refused <= refused_d;
      o_bcs_clear    <= bcs_clear_d;
      o_spi_reset    <= spi_reset_d;
      o_vec_hi_addr  <= vec_hi_d;
      o_vec_lo_addr  <= vec_lo_d;
    end
  end

  // ==========================================================================
  // clock and unit gating, derived from the next mode
  // ==========================================================================
  logic                   in_stop_d;    // next mode is stop
  logic                   in_wait_d;    // next mode is wait
  logic                   cpu_clk_d;
  logic                   bus_clk_d;
  lpw_pkg::lpw_clk_gate_t clk_gate_d;
  lpw_pkg::lpw_unit_ctl_t unit_d;

  // gates follow mode_d so they switch in the same edge as the mode
  always_comb begin
    in_stop_d = (mode_d == lpw_pkg::LPW_STOP);
    in_wait_d = (mode_d == lpw_pkg::LPW_WAIT);
    cpu_clk_d = (mode_d == lpw_pkg::LPW_RUN);
    bus_clk_d = ~in_stop_d | i_osc_run_in_stop;
    // clock generator untouched in wait; software owns select and power
    clk_gate_d.osc_en     = ~in_stop_d | i_osc_run_in_stop;
    clk_gate_d.pll_en     = i_pll_power_on & ~in_stop_d;
    clk_gate_d.xclk_en    = ~in_stop_d | i_osc_run_in_stop;
    clk_gate_d.bus_src_en = ~in_stop_d | i_osc_run_in_stop;
    // pll is off in any stop, so its interrupt has nothing to say
    clk_gate_d.pll_int_en = ~in_stop_d;
    unit_d.wdog_clk_en       = ~in_stop_d;
    unit_d.wdog_presc_clr    = in_stop_d;
    unit_d.sci_run           = ~in_stop_d;
    unit_d.spi_run           = ~in_stop_d;
    unit_d.timer_run         = ~in_stop_d;
    unit_d.tbm_run           = ~in_stop_d | i_osc_run_in_stop;
    unit_d.tbm_read_block    = in_stop_d | in_wait_d;
    unit_d.supply_mon_active = i_supply_mon_enable;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_cpu_clk_en <= 1'b1;
      o_bus_clk_en <= 1'b1;
      o_clk_gate   <= lpw_pkg::LPW_CLK_RESET;
      o_unit_ctl   <= lpw_pkg::LPW_UNIT_RESET;
      o_mode       <= lpw_pkg::LPW_RUN;
    end else begin
      o_cpu_clk_en <= cpu_clk_d;
      o_bus_clk_en <= bus_clk_d;
      o_clk_gate   <= clk_gate_d;
      o_unit_ctl   <= unit_d;
      o_mode       <= mode_d;
    end
  end

endmodule : lpw_ctrl

//--- rtl/lpw_pkg.sv
package lpw_pkg;

  // ==========================================================================
  // operating modes
  // ==========================================================================
  typedef enum logic [2:0] {
    LPW_RUN  = 3'b001,   // cpu clock running
    LPW_WAIT = 3'b010,   // cpu clock off, bus clock on
    LPW_STOP = 3'b100    // cpu clock off, bus clock per oscillator option
  } lpw_mode_t;

  // ==========================================================================
  // wake source slots, index order is priority order (higher index wins)
  // ==========================================================================
  localparam int unsigned LPW_NSRC        = 16;
  localparam int unsigned LPW_SRC_TBM     = 0;
  localparam int unsigned LPW_SRC_KEYPAD  = 1;   // shared with converter
  localparam int unsigned LPW_SRC_SCI_TX  = 2;
  localparam int unsigned LPW_SRC_SCI_RX  = 3;
  localparam int unsigned LPW_SRC_SCI_ERR = 4;
  localparam int unsigned LPW_SRC_SPI_TX  = 5;
  localparam int unsigned LPW_SRC_SPI_RX  = 6;
  localparam int unsigned LPW_SRC_T2_OVF  = 7;
  localparam int unsigned LPW_SRC_T2_CH0  = 8;
  localparam int unsigned LPW_SRC_T1_OVF  = 9;
  localparam int unsigned LPW_SRC_T1_CH1  = 10;
  localparam int unsigned LPW_SRC_T1_CH0  = 11;
  localparam int unsigned LPW_SRC_PLL     = 12;
  localparam int unsigned LPW_SRC_EXTINT  = 13;
  localparam int unsigned LPW_SRC_BREAK   = 14;
  localparam int unsigned LPW_SRC_RESET   = 15;  // pin, watchdog, supply

  // ==========================================================================
  // lower address of each vector pair, indexed by source slot
  // ==========================================================================
  localparam logic [15:0] LPW_VEC_ADDR [LPW_NSRC] = '{
    16'hFFDC, 16'hFFDE, 16'hFFE2, 16'hFFE4,
    16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEC,
    16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6,
    16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE
  };
  localparam logic [15:0] LPW_VEC_PAIR_STEP = 16'h0001;  // second byte offset
  localparam logic [15:0] LPW_VEC_IDLE      = 16'h0000;  // shown before any wake

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic t1_ovf;
    logic t1_ch1;
    logic t1_ch0;
    logic t2_ovf;
    logic t2_ch0;
    logic spi_tx;
    logic spi_rx;
    logic sci_tx;
    logic sci_rx;
    logic sci_err;
    logic adc_done;
    logic periodic_timebase;
  } lpw_periph_req_t;

  typedef struct packed {
    logic osc_en;        // crystal oscillator enable
    logic pll_en;        // pll enable
    logic xclk_en;       // crystal clock output gate
    logic bus_src_en;    // bus clock source output gate
    logic pll_int_en;    // pll interrupt output gate
  } lpw_clk_gate_t;

  typedef struct packed {
    logic sci_run;
    logic spi_run;
    logic timer_run;
    logic tbm_run;
    logic tbm_read_block;
    logic wdog_clk_en;
    logic wdog_presc_clr;
    logic supply_mon_active;
  } lpw_unit_ctl_t;

  localparam lpw_clk_gate_t LPW_CLK_RESET  = '{default: 1'b1, pll_en: 1'b0};
  localparam lpw_unit_ctl_t LPW_UNIT_RESET = '{default: 1'b0, sci_run: 1'b1,
                                               spi_run: 1'b1, timer_run: 1'b1,
                                               tbm_run: 1'b1, wdog_clk_en: 1'b1};

endpackage : lpw_pkg

//--- rtl/lpw_sync.sv
// ============================================================================
// two-stage synchroniser for pins
// ============================================================================
module lpw_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_reset_val,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;   // first stage, read only by second stage
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;   // second stage
  logic [W-1:0] sync_d;

  // next values
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // reset value is a parameter-like tie, held at idle level
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      meta_q <= i_reset_val;
      sync_q <= i_reset_val;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;

endmodule : lpw_sync

//--- rtl/lpw_vec_pick.sv
// ============================================================================
// priority pick of the highest pending wake source
// ============================================================================
module lpw_vec_pick #(
  parameter int unsigned N  = 16,
  parameter int unsigned IW = 4
) (
  // pending sources
  input  wire logic [N-1:0]  i_pending,
  // chosen source
  output logic               o_valid,
  output logic      [IW-1:0] o_index
);

  // scan upward so the highest index is the last to land
  always_comb begin
    o_valid = 1'b0;
    o_index = '0;
    for (int unsigned k = 0; k < N; k++) begin
      if (i_pending[k]) begin
        o_valid = 1'b1;
        o_index = IW'(k);
      end
    end
  end

endmodule : lpw_vec_pick

//--- tb/lpw_ctrl_monitor.sv
// ==========================================================================
// port checker for the low-power controller
module lpw_ctrl_monitor (
  // clock and reset
  input wire logic                    i_core_clk,
  input wire logic                    i_srst,
  // requests and options
  input wire logic                    i_stop_exec,
  input wire logic                    i_stop_enable,
  input wire logic                    i_osc_run_in_stop,
  input wire logic                    i_vco_drives_bus,
  input wire logic                    i_base_clock_select,
  input wire logic                    i_break_req,
  input wire logic                    i_wdog_timeout,
  input wire logic                    i_pll_req,
  // watched outputs
  input wire logic                    o_cpu_clk_en,
  input wire logic                    o_bus_clk_en,
  input wire logic                    o_wake,
  input wire logic                    o_reset_exit,
  input wire logic                    o_stop_refused,
  input wire logic [15:0]             o_vec_hi_addr,
  input wire logic [15:0]             o_vec_lo_addr,
  input wire lpw_pkg::lpw_mode_t      o_mode,
  input wire lpw_pkg::lpw_clk_gate_t  o_clk_gate,
  input wire logic                    o_bcs_clear,
  input wire lpw_pkg::lpw_unit_ctl_t  o_unit_ctl,
  input wire logic                    o_spi_reset
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  // mode decodes, stop counts only when taken in run
  logic in_run, in_wait, in_stop, go_stop;
  assign in_run  = o_mode == lpw_pkg::LPW_RUN;
  assign in_wait = o_mode == lpw_pkg::LPW_WAIT;
  assign in_stop = o_mode == lpw_pkg::LPW_STOP;
  assign go_stop = i_stop_exec && i_stop_enable && in_run;
  a_stop_clk_off: assert property (go_stop && !i_osc_run_in_stop |=>
    in_stop && o_clk_gate == '0 && !o_bus_clk_en && !o_cpu_clk_en)
    else $error("clocks on in stop");
  a_stop_osc_keep: assert property (go_stop && i_osc_run_in_stop |=>
    o_clk_gate.osc_en && !o_clk_gate.pll_en && o_bus_clk_en)
    else $error("osc option lost in stop");
  a_bcs_auto_clear: assert property (go_stop && i_vco_drives_bus && i_base_clock_select
    |=> o_bcs_clear) else $error("select not cleared");
  a_stop_refusal: assert property (i_stop_exec && !i_stop_enable && in_run |=>
    o_stop_refused && in_run) else $error("stop not refused");
  a_wait_units_run: assert property (in_wait |-> o_bus_clk_en && o_clk_gate.osc_en
    && o_unit_ctl.timer_run && o_unit_ctl.sci_run && o_unit_ctl.spi_run
    && o_unit_ctl.wdog_clk_en && o_unit_ctl.tbm_read_block && !o_cpu_clk_en)
    else $error("wait controls wrong");
  a_stop_units_halt: assert property (in_stop |-> !o_unit_ctl.timer_run
    && !o_unit_ctl.sci_run && !o_unit_ctl.spi_run && !o_unit_ctl.wdog_clk_en
    && o_unit_ctl.wdog_presc_clr && o_unit_ctl.tbm_read_block)
    else $error("stop controls wrong");
  a_wdog_wait_exit: assert property (in_wait && i_wdog_timeout |=>
    o_wake && o_reset_exit && o_vec_hi_addr == 16'hFFFE) else $error("wdog exit wrong");
  a_break_wait_exit: assert property (in_wait && i_break_req |=> o_wake &&
    (o_vec_hi_addr == 16'hFFFC || o_reset_exit)) else $error("break exit wrong");
  a_pll_wait_exit: assert property (in_wait && i_pll_req |=> o_wake &&
    o_vec_hi_addr >= 16'hFFF8) else $error("pll exit wrong");
  a_pair_order: assert property (o_wake |-> o_vec_lo_addr == o_vec_hi_addr + 16'h0001)
    else $error("pair order wrong");
  a_vec_hold: assert property (!o_wake && !$past(i_srst) |-> $stable(o_vec_hi_addr))
    else $error("vector moved");
  a_spi_reset_exit: assert property (o_spi_reset |-> o_reset_exit && o_wake
    && $past(o_mode) == lpw_pkg::LPW_STOP) else $error("stray spi reset");
  // main scenarios reached
  c_wait_wake: cover property (in_wait ##1 o_wake);
  c_stop_wake: cover property (in_stop ##1 o_wake);
  c_refused:   cover property (o_stop_refused);
endmodule : lpw_ctrl_monitor

bind lpw_ctrl lpw_ctrl_monitor lpw_ctrl_monitor_i (.*);

//--- tb/lpw_cpu_model.sv
// ==========================================================================
// cpu core stand-in: issues wait/stop, fetches pc from the vector pair
module lpw_cpu_model (
  // clock
  input  wire logic        i_core_clk,
  // exit side of the controller
  input  wire logic        i_wake,
  input  wire logic [15:0] i_vec_hi_addr,
  input  wire logic [15:0] i_vec_lo_addr,
  // instruction strobes and fetched pc
  output logic             o_wait_exec,
  output logic             o_stop_exec,
  output logic [15:0]      o_pc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_wait_exec = 1'b0;
    o_stop_exec = 1'b0;
    o_pc = 16'h0000;
  end
  // memory byte at each vector address is its own low byte, so order shows
  always @(posedge i_core_clk) begin
    if (i_wake === 1'b1) begin
      o_pc <= {i_vec_hi_addr[7:0], i_vec_lo_addr[7:0]};
    end
  end
  // one-cycle strobe, launched just after an edge
  task automatic exec(input logic stop);
    @(posedge i_core_clk);
    #2;
    o_stop_exec = stop;
    o_wait_exec = !stop;
    @(posedge i_core_clk);
    #2;
    o_stop_exec = 1'b0;
    o_wait_exec = 1'b0;
  endtask : exec
endmodule : lpw_cpu_model

//--- tb/lpw_ctrl_bench.sv
module lpw_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // stimulus and observed signals
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1, i_stop_enable = 1'b1, i_pll_power_on = 1'b1, i_ext_reset_n = 1'b1,
        i_ext_int_pin_n = 1'b1;
  logic i_osc_run_in_stop = 1'b0, i_base_clock_select = 1'b0, i_vco_drives_bus = 1'b0,
        i_supply_low = 1'b0, i_ext_int_mask = 1'b0, i_keypad_int_mask = 1'b0,
        i_supply_mon_enable = 1'b0, i_supply_mon_reset_enable = 1'b0;
  logic [15:0] req = 16'h0000;  // one bit per same-clock wake source
  logic i_wait_exec, i_stop_exec, o_cpu_clk_en, o_bus_clk_en, o_wake, o_reset_exit;
  logic o_stop_refused, o_bcs_clear, o_spi_reset;
  logic [15:0] o_vec_hi_addr, o_vec_lo_addr, pc;
  lpw_pkg::lpw_mode_t     o_mode;
  lpw_pkg::lpw_clk_gate_t o_clk_gate;
  lpw_pkg::lpw_unit_ctl_t o_unit_ctl;
  // expected pair per req bit (periph struct lsb first, keypad, pll, break, wdog)
  logic [15:0] exp_vec [16] = '{16'hFFDC, 16'hFFDE, 16'hFFE6, 16'hFFE4, 16'hFFE2,
    16'hFFEA, 16'hFFE8, 16'hFFF0, 16'hFFEC, 16'hFFF6, 16'hFFF4, 16'hFFF2,
    16'hFFDE, 16'hFFF8, 16'hFFFC, 16'hFFFE};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  lpw_ctrl lpw_ctrl_i (.*, .i_periph_req(req[11:0]), .i_keypad_req(req[12]),
    .i_pll_req(req[13]), .i_break_req(req[14]), .i_wdog_timeout(req[15]));
  lpw_cpu_model lpw_cpu_model_i (.i_core_clk(i_core_clk), .i_wake(o_wake),
    .i_vec_hi_addr(o_vec_hi_addr), .i_vec_lo_addr(o_vec_lo_addr),
    .o_wait_exec(i_wait_exec), .o_stop_exec(i_stop_exec), .o_pc(pc));
  always #25 i_core_clk = ~i_core_clk;
  // hang guard: tests need about 120 cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask : step
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // bounded wait for the exit pulse, then judge vector and pc
  task automatic expect_wake(input logic [15:0] vec, input logic rst, input logic spi);
    int n;
    n = 0;
    while (o_wake !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    check(o_vec_hi_addr, vec);
    check({o_wake, o_reset_exit, o_spi_reset}, {1'b1, rst, spi});
    check(o_mode, lpw_pkg::LPW_RUN);
    step(1);
    check(pc, {vec[7:0], vec[7:0] + 8'h01});
  endtask : expect_wake
  task automatic enter_wait();
    lpw_cpu_model_i.exec(1'b0);
    check(o_mode, lpw_pkg::LPW_WAIT);
    check({o_bus_clk_en, o_clk_gate.osc_en, o_unit_ctl.tbm_read_block}, 3'h7);
    check(o_clk_gate.pll_en, i_pll_power_on);
  endtask : enter_wait
  // ==========================================================================
  // scenarios
  task automatic t_wait_sources();
    for (int k = 0; k < 16; k++) begin
      enter_wait();
      req[k] = 1'b1;
      expect_wake(exp_vec[k], k == 15, 1'b0);
      req[k] = 1'b0;
    end
    $display("wait sources done");
  endtask : t_wait_sources
  task automatic t_masks();
    i_keypad_int_mask = 1'b1;
    i_ext_int_mask = 1'b1;
    enter_wait();
    req[12] = 1'b1;
    i_ext_int_pin_n = 1'b0;
    step(6);
    check(o_mode, lpw_pkg::LPW_WAIT);
    i_keypad_int_mask = 1'b0;
    expect_wake(16'hFFDE, 1'b0, 1'b0);
    req[12] = 1'b0;
    i_ext_int_pin_n = 1'b1;
    enter_wait();
    i_ext_int_mask = 1'b0;
    step(3);
    i_ext_int_pin_n = 1'b0;
    expect_wake(16'hFFFA, 1'b0, 1'b0);
    i_ext_int_pin_n = 1'b1;
    $display("masks done");
  endtask : t_masks
  task automatic t_stop_refused();
    i_stop_enable = 1'b0;
    lpw_cpu_model_i.exec(1'b1);
    check({o_stop_refused, o_cpu_clk_en}, 2'h3);
    i_stop_enable = 1'b1;
    $display("stop refused done");
  endtask : t_stop_refused
  task automatic t_stop_osc_off();
    i_vco_drives_bus = 1'b1;
    i_base_clock_select = 1'b1;
    lpw_cpu_model_i.exec(1'b1);
    check(o_bcs_clear, 1'b1);
    check({o_cpu_clk_en, o_bus_clk_en, o_clk_gate}, 7'h00);
    check(o_unit_ctl, 8'h0A);
    i_vco_drives_bus = 1'b0;
    i_base_clock_select = 1'b0;
    req = 16'hA801;
    step(4);
    check(o_mode, lpw_pkg::LPW_STOP);
    i_ext_reset_n = 1'b0;
    expect_wake(16'hFFFE, 1'b1, 1'b1);
    i_ext_reset_n = 1'b1;
    req = 16'h0000;
    $display("stop osc off done");
  endtask : t_stop_osc_off
  task automatic t_stop_osc_on();
    i_osc_run_in_stop = 1'b1;
    lpw_cpu_model_i.exec(1'b1);
    check({o_clk_gate.osc_en, o_clk_gate.pll_en, o_bus_clk_en}, 3'h5);
    check({o_unit_ctl.tbm_run, o_unit_ctl.timer_run}, 2'h2);
    req[0] = 1'b1;
    expect_wake(16'hFFDC, 1'b0, 1'b0);
    req[0] = 1'b0;
    i_osc_run_in_stop = 1'b0;
    $display("stop osc on done");
  endtask : t_stop_osc_on
  task automatic t_supply();
    i_supply_mon_enable = 1'b1;
    i_supply_mon_reset_enable = 1'b1;
    i_pll_power_on = 1'b0;
    enter_wait();
    check(o_unit_ctl.supply_mon_active, 1'b1);
    i_supply_low = 1'b1;
    expect_wake(16'hFFFE, 1'b1, 1'b0);
    i_supply_low = 1'b0;
    $display("supply done");
  endtask : t_supply
  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge i_core_clk);
    #2;
    i_srst = 1'b0;
    t_wait_sources();
    t_masks();
    t_stop_refused();
    t_stop_osc_off();
    t_stop_osc_on();
    t_supply();
    finish_test();
  end
endmodule : lpw_ctrl_bench
